// [camera_command_interpreter.sv]
// Command interpreter: frame parsing, execution and response framing
//
// Summary of operation
// - Exposure command 0x45 carries 16-bit steps, high first, valid 2..960.
// - Exposure setting is 672 steps after reset until changed.
// - Exposure setting kept; acknowledged with zero telemetry bytes.
// - Capture 0x43 picks one of four slots; high definition ignores slot.
// - Image is 640x480 or 1280x960 one-byte pixels by current mode.
// - Test flag 0x01 stores a repeating 0-255 pattern, 0x00 real image.
// - Capture acknowledge carries two bytes of exposure used.
// - Download 0x44: slot, preview flag, 16-bit line; one line returned.
// - Download ignores current mode; high definition reads four slots.
// - Preview 0x00 gives 640-byte lines, 0x01 gives 80-byte lines.
// - Lines from zero, any order or repeat; capture accepted in any mode but sleep.
// - Line number bytes lead pixels; length 0x0282 or 0x0052.
// - Register read 0x52 returns address echo then 16-bit data.
// - Sensor exposure register 0x3012 reads 0x02a0 or the set value.
// - Register write 0x57 writes sensor data, acknowledged with none.
// - Errors answer 0xff, length three: command, type, count.
// - Error types: 0 unknown, 1 command, 2 parameter, 3 mode, 4 sensor.
// - Error count is 8 bits of error responses, sensor failures included, wrapping.
// - Response: 0x40, ack, mode, 16-bit length, telemetry, 0x0d.
// - Mode byte: 0 sleep, 1 standard, 2 zoom, 3 high definition.
`timescale 1ns/10ps
module camera_command_interpreter (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_N_I,
  input  wire logic        RX_VALID_I,
  input  wire logic [7:0]  RX_DATA_I,
  output logic             RX_READY_O,
  output logic             TX_VALID_O,
  output logic [7:0]       TX_DATA_O,
  input  wire logic        TX_READY_I,
  input  wire logic [1:0]  MODE_I,
  output logic             SENS_REQ_O,
  output logic             SENS_WRITE_O,
  output logic [15:0]      SENS_ADDR_O,
  output logic [15:0]      SENS_WDATA_O,
  input  wire logic [15:0] SENS_RDATA_I,
  input  wire logic        SENS_DONE_I,
  input  wire logic        SENS_ERR_I,
  output logic             CAP_REQ_O,
  output logic [1:0]       CAP_SLOT_O,
  output logic             CAP_HD_O,
  output logic             CAP_TEST_O,
  output logic [15:0]      CAP_EXPOSURE_O,
  input  wire logic        CAP_DONE_I,
  input  wire logic        CAP_ERR_I,
  output logic             MEM_REQ_O,
  output logic [1:0]       MEM_SLOT_O,
  output logic             MEM_PREVIEW_O,
  output logic [8:0]       MEM_LINE_O,
  output logic [9:0]       MEM_COL_O,
  input  wire logic [7:0]  MEM_DATA_I,
  input  wire logic        MEM_ACK_I
);

  cam_cmd_pkg::state_e state_q;
  cam_cmd_pkg::state_e state_d;
  logic [2:0]  rx_idx_q;
  logic [2:0]  rx_idx_d;
  logic [7:0]  cmd_q;
  logic [7:0]  cmd_d;
  logic [7:0]  par_q [4];
  logic [7:0]  par_d [4];
  logic        bad_frame_q;
  logic        bad_frame_d;
  logic [15:0] exposure_q;
  logic [15:0] exposure_d;
  logic [7:0]  err_cnt_q;
  logic [7:0]  err_cnt_d;
  logic [7:0]  ack_q;
  logic [7:0]  ack_d;
  logic [15:0] len_q;
  logic [15:0] len_d;
  logic [7:0]  tlm_q [4];
  logic [7:0]  tlm_d [4];
  logic        is_dl_q;
  logic        is_dl_d;
  logic [3:0]  tx_idx_q;
  logic [3:0]  tx_idx_d;
  logic [9:0]  pix_cnt_q;
  logic [9:0]  pix_cnt_d;
  logic [7:0]  pix_q;
  logic [7:0]  pix_d;
  logic        sens_req_q;
  logic        sens_req_d;
  logic        sens_wr_q;
  logic        sens_wr_d;
  logic        cap_req_q;
  logic        cap_req_d;
  logic        cap_hd_q;
  logic        cap_hd_d;
  logic        mem_req_q;
  logic        mem_req_d;

  logic        start_err;
  logic [7:0]  err_type;
  logic        start_tx;
  logic        push;
  logic [7:0]  push_data;
  logic [3:0]  fixed_len;
  logic [3:0]  tlm_off;
  logic [9:0]  line_len;
  logic [15:0] par_hi;
  logic [15:0] par_lo;
  logic [15:0] line_lim;

  byte_stream_if resp_in ();
  byte_stream_if resp_out ();

  response_buffer u_buffer (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RST_N_I),
    .in_s    (resp_in),
    .out_s   (resp_out)
  );

  assign resp_in.valid  = push;
  assign resp_in.data   = push_data;
  assign TX_VALID_O     = resp_out.valid;
  assign TX_DATA_O      = resp_out.data;
  assign resp_out.ready = TX_READY_I;

  assign RX_READY_O     = (state_q == cam_cmd_pkg::ST_RX);
  assign SENS_REQ_O     = sens_req_q;
  assign SENS_WRITE_O   = sens_wr_q;
  assign SENS_ADDR_O    = {par_q[0], par_q[1]};
  assign SENS_WDATA_O   = {par_q[2], par_q[3]};
  assign CAP_REQ_O      = cap_req_q;
  assign CAP_SLOT_O     = par_q[0][1:0];
  assign CAP_HD_O       = cap_hd_q;
  assign CAP_TEST_O     = par_q[1][0];
  assign CAP_EXPOSURE_O = exposure_q;
  assign MEM_REQ_O      = mem_req_q;
  assign MEM_SLOT_O     = par_q[0][1:0];
  assign MEM_PREVIEW_O  = par_q[1][0];
  assign MEM_LINE_O     = {par_q[2][0], par_q[3]};
  assign MEM_COL_O      = pix_cnt_q;

  assign par_hi    = {par_q[0], par_q[1]};
  assign par_lo    = {par_q[2], par_q[3]};
  assign line_len  = par_q[1][0] ? cam_cmd_pkg::PREVIEW_LINE_LEN
                                 : cam_cmd_pkg::FULL_LINE_LEN;
  assign line_lim  = par_q[1][0] ? cam_cmd_pkg::PREVIEW_LINES
                                 : cam_cmd_pkg::FULL_LINES;
  assign fixed_len = is_dl_q ? cam_cmd_pkg::DL_FIXED_LEN : len_q[3:0];
  assign tlm_off   = tx_idx_q - cam_cmd_pkg::HEADER_LEN;

  // Response byte selection
  always_comb begin
    unique case (tx_idx_q)
      4'h0:    push_data = cam_cmd_pkg::FRAME_START;
      4'h1:    push_data = ack_q;
      4'h2:    push_data = {6'h00, MODE_I};
      4'h3:    push_data = len_q[15:8];
      4'h4:    push_data = len_q[7:0];
      default: push_data = (tlm_off < fixed_len) ? tlm_q[tlm_off[1:0]]
                                                 : cam_cmd_pkg::FRAME_END;
    endcase
    if (state_q == cam_cmd_pkg::ST_PIXEL) begin
      push_data = pix_q;
    end
  end

  always_comb begin
    state_d     = state_q;
    rx_idx_d    = rx_idx_q;
    cmd_d       = cmd_q;
    par_d       = par_q;
    bad_frame_d = bad_frame_q;
    exposure_d  = exposure_q;
    err_cnt_d   = err_cnt_q;
    ack_d       = ack_q;
    len_d       = len_q;
    tlm_d       = tlm_q;
    is_dl_d     = is_dl_q;
    tx_idx_d    = tx_idx_q;
    pix_cnt_d   = pix_cnt_q;
    pix_d       = pix_q;
    sens_req_d  = sens_req_q;
    sens_wr_d   = sens_wr_q;
    cap_req_d   = cap_req_q;
    cap_hd_d    = cap_hd_q;
    mem_req_d   = mem_req_q;
    start_err   = 1'b0;
    err_type    = cam_cmd_pkg::ERR_UNKNOWN;
    start_tx    = 1'b0;
    push        = 1'b0;
    unique case (state_q)
      cam_cmd_pkg::ST_RX: begin
        if (RX_VALID_I) begin
          rx_idx_d = rx_idx_q + 3'h1;
          if (rx_idx_q == 3'h0) begin
            bad_frame_d = 1'b0;
            if (RX_DATA_I != cam_cmd_pkg::FRAME_START) begin
              rx_idx_d = 3'h0;
            end
          end else if (rx_idx_q == 3'h1) begin
            cmd_d = RX_DATA_I;
          end else if (rx_idx_q == cam_cmd_pkg::FRAME_LAST_IDX) begin
            rx_idx_d    = 3'h0;
            state_d     = cam_cmd_pkg::ST_EXEC;
            bad_frame_d = (RX_DATA_I != cam_cmd_pkg::FRAME_END);
          end else begin
            par_d[2'(rx_idx_q - cam_cmd_pkg::FRAME_PARAM_IDX)] = RX_DATA_I;
          end
        end
      end
      cam_cmd_pkg::ST_EXEC: begin
        ack_d   = cmd_q;
        len_d   = cam_cmd_pkg::LEN_NONE;
        is_dl_d = 1'b0;
        if (bad_frame_q) begin
          start_err = 1'b1;
          err_type  = cam_cmd_pkg::ERR_UNRECOGNISED;
        end else begin
          unique case (cmd_q)
            cam_cmd_pkg::CMD_EXPOSURE: begin
              if (par_hi < cam_cmd_pkg::EXPOSURE_MIN ||
                  par_hi > cam_cmd_pkg::EXPOSURE_MAX) begin
                start_err = 1'b1;
                err_type  = cam_cmd_pkg::ERR_PARAMETER;
              end else if (MODE_I == cam_cmd_pkg::MODE_SLEEP) begin
                exposure_d = par_hi;
                start_tx   = 1'b1;
              end else begin
                par_d[2]   = par_q[0];
                par_d[3]   = par_q[1];
                par_d[0]   = cam_cmd_pkg::EXPOSURE_REG[15:8];
                par_d[1]   = cam_cmd_pkg::EXPOSURE_REG[7:0];
                sens_req_d = 1'b1;
                sens_wr_d  = 1'b1;
                state_d    = cam_cmd_pkg::ST_SENSOR;
              end
            end
            cam_cmd_pkg::CMD_CAPTURE: begin
              if (par_q[1] > cam_cmd_pkg::FLAG_MAX ||
                  (MODE_I != cam_cmd_pkg::MODE_HIGH_DEF &&
                   par_q[0] > cam_cmd_pkg::SLOT_MAX)) begin
                start_err = 1'b1;
                err_type  = cam_cmd_pkg::ERR_PARAMETER;
              end else if (MODE_I == cam_cmd_pkg::MODE_SLEEP) begin
                start_err = 1'b1;
                err_type  = cam_cmd_pkg::ERR_WRONG_MODE;
              end else begin
                cap_req_d = 1'b1;
                cap_hd_d  = (MODE_I == cam_cmd_pkg::MODE_HIGH_DEF);
                state_d   = cam_cmd_pkg::ST_CAPTURE;
              end
            end
            cam_cmd_pkg::CMD_DOWNLOAD: begin
              if (par_q[0] > cam_cmd_pkg::SLOT_MAX ||
                  par_q[1] > cam_cmd_pkg::FLAG_MAX ||
                  par_lo >= line_lim) begin
                start_err = 1'b1;
                err_type  = cam_cmd_pkg::ERR_PARAMETER;
              end else begin
                is_dl_d  = 1'b1;
                len_d    = par_q[1][0] ? cam_cmd_pkg::LEN_PREVIEW
                                       : cam_cmd_pkg::LEN_FULL;
                tlm_d[0] = par_q[2];
                tlm_d[1] = par_q[3];
                start_tx = 1'b1;
              end
            end
            cam_cmd_pkg::CMD_REG_READ,
            cam_cmd_pkg::CMD_REG_WRITE: begin
              if (MODE_I == cam_cmd_pkg::MODE_SLEEP) begin
                start_err = 1'b1;
                err_type  = cam_cmd_pkg::ERR_WRONG_MODE;
              end else begin
                sens_req_d = 1'b1;
                sens_wr_d  = (cmd_q == cam_cmd_pkg::CMD_REG_WRITE);
                state_d    = cam_cmd_pkg::ST_SENSOR;
              end
            end
            default: begin
              start_err = 1'b1;
              err_type  = cam_cmd_pkg::ERR_UNRECOGNISED;
            end
          endcase
        end
      end
      cam_cmd_pkg::ST_SENSOR: begin
        if (SENS_DONE_I) begin
          sens_req_d = 1'b0;
          if (SENS_ERR_I) begin
            start_err = 1'b1;
            err_type  = cam_cmd_pkg::ERR_SENSOR;
          end else begin
            start_tx = 1'b1;
            if (!sens_wr_q) begin
              len_d    = cam_cmd_pkg::LEN_REG_READ;
              tlm_d[0] = par_q[0];
              tlm_d[1] = par_q[1];
              tlm_d[2] = SENS_RDATA_I[15:8];
              tlm_d[3] = SENS_RDATA_I[7:0];
            end else if (par_hi == cam_cmd_pkg::EXPOSURE_REG) begin
              exposure_d = par_lo;
            end
          end
        end
      end
      cam_cmd_pkg::ST_CAPTURE: begin
        if (CAP_DONE_I) begin
          cap_req_d = 1'b0;
          if (CAP_ERR_I) begin
            start_err = 1'b1;
            err_type  = cam_cmd_pkg::ERR_SENSOR;
          end else begin
            len_d    = cam_cmd_pkg::LEN_CAPTURE;
            tlm_d[0] = exposure_q[15:8];
            tlm_d[1] = exposure_q[7:0];
            start_tx = 1'b1;
          end
        end
      end
      cam_cmd_pkg::ST_SEND: begin
        if (tlm_off == fixed_len && is_dl_q && pix_cnt_q != line_len) begin
          mem_req_d = 1'b1;
          state_d   = cam_cmd_pkg::ST_FETCH;
        end else begin
          push = 1'b1;
          if (resp_in.ready) begin
            tx_idx_d = tx_idx_q + 4'h1;
            if (tx_idx_q >= cam_cmd_pkg::HEADER_LEN &&
                tlm_off == fixed_len) begin
              state_d = cam_cmd_pkg::ST_RX;
            end
          end
        end
      end
      cam_cmd_pkg::ST_FETCH: begin
        if (MEM_ACK_I) begin
          mem_req_d = 1'b0;
          pix_d     = MEM_DATA_I;
          state_d   = cam_cmd_pkg::ST_PIXEL;
        end
      end
      cam_cmd_pkg::ST_PIXEL: begin
        push = 1'b1;
        if (resp_in.ready) begin
          pix_cnt_d = pix_cnt_q + 10'h001;
          if (pix_cnt_d == line_len) begin
            state_d = cam_cmd_pkg::ST_SEND;
          end else begin
            mem_req_d = 1'b1;
            state_d   = cam_cmd_pkg::ST_FETCH;
          end
        end
      end
    endcase
    if (start_err) begin
      err_cnt_d = err_cnt_q + 8'h01;
      ack_d     = cam_cmd_pkg::ACK_ERROR;
      len_d     = cam_cmd_pkg::LEN_ERROR;
      tlm_d[0]  = cmd_q;
      tlm_d[1]  = err_type;
      tlm_d[2]  = err_cnt_d;
      is_dl_d   = 1'b0;
      start_tx  = 1'b1;
    end
    if (start_tx) begin
      tx_idx_d  = 4'h0;
      pix_cnt_d = 10'h000;
      state_d   = cam_cmd_pkg::ST_SEND;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q     <= cam_cmd_pkg::ST_RX;
      rx_idx_q    <= 3'h0;
      cmd_q       <= 8'h00;
      par_q       <= '{default: 8'h00};
      bad_frame_q <= 1'b0;
      exposure_q  <= cam_cmd_pkg::EXPOSURE_RESET;
      err_cnt_q   <= 8'h00;
      ack_q       <= 8'h00;
      len_q       <= 16'h0000;
      tlm_q       <= '{default: 8'h00};
      is_dl_q     <= 1'b0;
      tx_idx_q    <= 4'h0;
      pix_cnt_q   <= 10'h000;
      pix_q       <= 8'h00;
      sens_req_q  <= 1'b0;
      sens_wr_q   <= 1'b0;
      cap_req_q   <= 1'b0;
      cap_hd_q    <= 1'b0;
      mem_req_q   <= 1'b0;
    end else begin
      state_q     <= state_d;
      rx_idx_q    <= rx_idx_d;
      cmd_q       <= cmd_d;
      par_q       <= par_d;
      bad_frame_q <= bad_frame_d;
      exposure_q  <= exposure_d;
      err_cnt_q   <= err_cnt_d;
      ack_q       <= ack_d;
      len_q       <= len_d;
      tlm_q       <= tlm_d;
      is_dl_q     <= is_dl_d;
      tx_idx_q    <= tx_idx_d;
      pix_cnt_q   <= pix_cnt_d;
      pix_q       <= pix_d;
      sens_req_q  <= sens_req_d;
      sens_wr_q   <= sens_wr_d;
      cap_req_q   <= cap_req_d;
      cap_hd_q    <= cap_hd_d;
      mem_req_q   <= mem_req_d;
    end
  end

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_sens_write_ok;
    state_q == cam_cmd_pkg::ST_SENSOR && SENS_DONE_I && !SENS_ERR_I &&
    sens_wr_q && par_hi == cam_cmd_pkg::EXPOSURE_REG;
  endsequence

  sequence s_cap_ok;
    state_q == cam_cmd_pkg::ST_CAPTURE && CAP_DONE_I && !CAP_ERR_I;
  endsequence

  chk_exposure_reset: assert property ($rose(RST_N_I) |->
    exposure_q == cam_cmd_pkg::EXPOSURE_RESET)
    else $error("exposure not at default after reset");
  chk_exposure_store: assert property (s_sens_write_ok |=>
    exposure_q == $past(par_lo) && len_q == cam_cmd_pkg::LEN_NONE)
    else $error("exposure register write not kept");
  chk_capture_tlm: assert property (s_cap_ok |=>
    len_q == cam_cmd_pkg::LEN_CAPTURE && {tlm_q[0], tlm_q[1]} == exposure_q)
    else $error("capture ack lacks exposure");
  chk_err_count: assert property (start_err |=>
    err_cnt_q == $past(err_cnt_q) + 8'h01 && tlm_q[2] == err_cnt_q)
    else $error("error count not stepped");
  chk_err_frame: assert property (start_err |=>
    ack_q == cam_cmd_pkg::ACK_ERROR && len_q == cam_cmd_pkg::LEN_ERROR)
    else $error("error response malformed");
  chk_bad_exposure: assert property (state_q == cam_cmd_pkg::ST_EXEC &&
    !bad_frame_q && cmd_q == cam_cmd_pkg::CMD_EXPOSURE &&
    par_hi > cam_cmd_pkg::EXPOSURE_MAX |=>
    tlm_q[1] == cam_cmd_pkg::ERR_PARAMETER)
    else $error("out of range exposure accepted");
  chk_dl_length: assert property (is_dl_q &&
    state_q == cam_cmd_pkg::ST_SEND |->
    len_q == (par_q[1][0] ? cam_cmd_pkg::LEN_PREVIEW : cam_cmd_pkg::LEN_FULL))
    else $error("download length wrong");
  chk_frame_start: assert property (push && tx_idx_q == 4'h0 &&
    state_q == cam_cmd_pkg::ST_SEND |->
    push_data == cam_cmd_pkg::FRAME_START)
    else $error("response does not open with start byte");
  chk_pixel_bound: assert property (state_q == cam_cmd_pkg::ST_PIXEL |->
    pix_cnt_q < line_len)
    else $error("too many pixels in line");
  chk_unknown_cmd: assert property (state_q == cam_cmd_pkg::ST_EXEC &&
    bad_frame_q |=> tlm_q[1] == cam_cmd_pkg::ERR_UNRECOGNISED [*2])
    else $error("bad frame not flagged");

endmodule

// [cam_cmd_pkg.sv]
// Constants, codes and states of the camera command interpreter
package cam_cmd_pkg;

  localparam logic [7:0]  FRAME_START      = 8'h40;
  localparam logic [7:0]  FRAME_END        = 8'h0d;
  localparam logic [2:0]  FRAME_LAST_IDX   = 3'h6;
  localparam logic [2:0]  FRAME_PARAM_IDX  = 3'h2;

  localparam logic [7:0]  CMD_EXPOSURE     = 8'h45;
  localparam logic [7:0]  CMD_CAPTURE      = 8'h43;
  localparam logic [7:0]  CMD_DOWNLOAD     = 8'h44;
  localparam logic [7:0]  CMD_REG_READ     = 8'h52;
  localparam logic [7:0]  CMD_REG_WRITE    = 8'h57;
  localparam logic [7:0]  ACK_ERROR        = 8'hff;

  localparam logic [7:0]  ERR_UNKNOWN      = 8'h00;
  localparam logic [7:0]  ERR_UNRECOGNISED = 8'h01;
  localparam logic [7:0]  ERR_PARAMETER    = 8'h02;
  localparam logic [7:0]  ERR_WRONG_MODE   = 8'h03;
  localparam logic [7:0]  ERR_SENSOR       = 8'h04;

  localparam logic [1:0]  MODE_SLEEP       = 2'h0;
  localparam logic [1:0]  MODE_STANDARD    = 2'h1;
  localparam logic [1:0]  MODE_ZOOM        = 2'h2;
  localparam logic [1:0]  MODE_HIGH_DEF    = 2'h3;

  // Exposure in steps of 89.5 us
  localparam logic [15:0] EXPOSURE_RESET   = 16'h02a0;
  localparam logic [15:0] EXPOSURE_MIN     = 16'h0002;
  localparam logic [15:0] EXPOSURE_MAX     = 16'h03c0;
  localparam logic [15:0] EXPOSURE_REG     = 16'h3012;

  localparam logic [7:0]  SLOT_MAX         = 8'h03;
  localparam logic [7:0]  FLAG_MAX         = 8'h01;
  localparam logic [15:0] FULL_LINES       = 16'h01e0;
  localparam logic [15:0] PREVIEW_LINES    = 16'h003c;
  localparam logic [9:0]  FULL_LINE_LEN    = 10'h280;
  localparam logic [9:0]  PREVIEW_LINE_LEN = 10'h050;
  localparam logic [15:0] LEN_FULL         = 16'h0282;
  localparam logic [15:0] LEN_PREVIEW      = 16'h0052;
  localparam logic [15:0] LEN_NONE         = 16'h0000;
  localparam logic [15:0] LEN_CAPTURE      = 16'h0002;
  localparam logic [15:0] LEN_REG_READ     = 16'h0004;
  localparam logic [15:0] LEN_ERROR        = 16'h0003;
  localparam logic [3:0]  DL_FIXED_LEN     = 4'h2;
  localparam logic [3:0]  HEADER_LEN       = 4'h5;

  typedef enum logic [2:0] {
    ST_RX,
    ST_EXEC,
    ST_SENSOR,
    ST_CAPTURE,
    ST_SEND,
    ST_FETCH,
    ST_PIXEL
  } state_e;

endpackage

// [byte_stream_if.sv]
// Byte stream with valid and ready between internal blocks
`timescale 1ns/10ps
interface byte_stream_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [response_buffer.sv]
// Two-entry buffer on the response byte path
`timescale 1ns/10ps
module response_buffer (
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  byte_stream_if.snk  in_s,
  byte_stream_if.src  out_s
);

  logic [7:0] mem_q [2];
  logic [7:0] mem_d [2];
  logic       wr_q;
  logic       wr_d;
  logic       rd_q;
  logic       rd_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       push;
  logic       pop;

  assign in_s.ready  = (cnt_q != 2'h2);
  assign out_s.valid = (cnt_q != 2'h0);
  assign out_s.data  = mem_q[rd_q];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_s.data;
      wr_d        = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_q[0] <= 8'h00;
      mem_q[1] <= 8'h00;
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

endmodule

// [cam_host_model.sv]
// Host model: sends command frames, gathers framed responses
`timescale 1ns/10ps
module cam_host_model (
  input  wire logic       clk_i,
  input  wire logic       rx_ready_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic [7:0] term_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            tx_ready_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
    tx_ready_o = 1'b0;
  end
  task automatic send(input logic [39:0] body, output bit ok);
    logic [55:0] f;
    int          n;
    f = {8'h40, body, term_i};
    ok = 1'b1;
    for (int i = 6; i >= 0; i--) begin
      for (n = 0; rx_ready_i !== 1'b1 && n < 3000; n++) @(negedge clk_i);
      if (n == 3000) ok = 1'b0;
      rx_valid_o = 1'b1;
      rx_data_o  = f[i*8 +: 8];
      @(negedge clk_i);
    end
    rx_valid_o = 1'b0;
    rx_data_o  = ~rx_data_o;
  endtask
  // Stalls every other cycle so the response buffer fills
  task automatic recv(output logic [7:0] r[$], output bit ok);
    int n;
    r = {};
    tx_ready_o = 1'b1;
    for (n = 0; n < 4000; n++) begin
      // Byte seen here moves at the coming rising edge
      if (tx_valid_i === 1'b1 && tx_ready_o) r.push_back(tx_data_i);
      @(negedge clk_i);
      if (r.size() > 4 && r.size() == {r[3], r[4]} + 6) break;
      tx_ready_o = ~tx_ready_o;
    end
    tx_ready_o = 1'b0;
    ok = n < 4000;
  endtask
endmodule

// [tb_camera_command_interpreter.sv]
// Testbench of the camera command interpreter
`timescale 1ns/10ps
module tb_camera_command_interpreter;
  logic        clk_sys = 0, rst_n = 0, sens_done = 0, cap_done = 0;
  logic        mem_ack = 0, rx_valid, rx_ready, tx_valid, tx_ready;
  logic        sens_req, sens_write, cap_req, cap_hd, cap_test, mem_req;
  logic        mem_prev, fail = 0;
  logic [7:0]  term = 8'h0d;
  logic [1:0]  mode = 2'h1, cap_slot, mem_slot;
  logic [7:0]  rx_data, tx_data, mem_data = 8'h00;
  logic [8:0]  mem_line;
  logic [9:0]  mem_col;
  logic [15:0] sens_addr, sens_wdata, cap_exp, sens_reg = 16'h02a0;
  logic [19:0] cap_seen = '0;
  logic [11:0] mem_seen = '0;
  int          checked = 0, error_cnt = 0;
  always #50 clk_sys = ~clk_sys;
  // Sensor, capture and memory responders
  always @(negedge clk_sys) begin
    sens_done <= sens_req & ~sens_done;
    cap_done  <= cap_req & ~cap_done;
    mem_ack   <= mem_req & ~mem_ack;
    mem_data  <= mem_col[7:0];
    if (cap_req) cap_seen <= {cap_hd, cap_slot, cap_test, cap_exp};
    if (mem_req) mem_seen <= {mem_slot, mem_prev, mem_line};
    if (sens_done && sens_write && sens_addr == 16'h3012)
      sens_reg <= sens_wdata;
  end
  camera_command_interpreter camera_command_interpreter_i (
    .CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .RX_VALID_I(rx_valid),
    .RX_DATA_I(rx_data), .RX_READY_O(rx_ready), .TX_VALID_O(tx_valid),
    .TX_DATA_O(tx_data), .TX_READY_I(tx_ready), .MODE_I(mode),
    .SENS_REQ_O(sens_req), .SENS_WRITE_O(sens_write),
    .SENS_ADDR_O(sens_addr), .SENS_WDATA_O(sens_wdata),
    .SENS_RDATA_I(sens_reg), .SENS_DONE_I(sens_done), .SENS_ERR_I(fail),
    .CAP_REQ_O(cap_req), .CAP_SLOT_O(cap_slot), .CAP_HD_O(cap_hd),
    .CAP_TEST_O(cap_test), .CAP_EXPOSURE_O(cap_exp),
    .CAP_DONE_I(cap_done), .CAP_ERR_I(fail), .MEM_REQ_O(mem_req),
    .MEM_SLOT_O(mem_slot), .MEM_PREVIEW_O(mem_prev),
    .MEM_LINE_O(mem_line), .MEM_COL_O(mem_col), .MEM_DATA_I(mem_data),
    .MEM_ACK_I(mem_ack));
  cam_host_model cam_host_model_i (
    .clk_i(clk_sys), .rx_ready_i(rx_ready), .tx_valid_i(tx_valid),
    .tx_data_i(tx_data), .term_i(term), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data),
    .tx_ready_o(tx_ready));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] e, s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask
  // Sends one frame, compares header, up to four telemetry bytes, end
  task automatic run(input logic [39:0] body, input logic [7:0] ack,
                     input logic [15:0] len, input logic [31:0] tlm);
    logic [7:0]  r[$];
    logic [31:0] t;
    bit          ok;
    cam_host_model_i.send(body, ok);
    if (ok) cam_host_model_i.recv(r, ok);
    if (!ok) begin
      error_cnt++;
      conclude();
    end
    t = '0;
    for (int i = 0; i < 4 && 5 + i < r.size() - 1; i++)
      t[31 - 8*i -: 8] = r[5 + i];
    check("start", 8'h40, r[0]);
    check("ack", ack, r[1]);
    check("mode", {6'h00, mode}, r[2]);
    check("length", len, {r[3], r[4]});
    check("telemetry", tlm, t);
    check("end", 8'h0d, r[r.size() - 1]);
  endtask
  task automatic t_default_exposure();
    run({8'h52, 32'h30120000}, 8'h52, 16'h0004, 32'h301202a0);
  endtask
  task automatic t_set_exposure();
    run({8'h45, 32'h000a0000}, 8'h45, 16'h0000, 32'h0);
    run({8'h52, 32'h30120000}, 8'h52, 16'h0004, 32'h3012000a);
  endtask
  task automatic t_errors();
    run({8'h45, 32'h03c10000}, 8'hff, 16'h0003, 32'h45020100);
    run({8'h5a, 32'h00000000}, 8'hff, 16'h0003, 32'h5a010200);
  endtask
  task automatic t_capture();
    run({8'h43, 32'h02010000}, 8'h43, 16'h0002, 32'h000a0000);
    check("capture", {1'b0, 2'h2, 1'b1, 16'h000a}, cap_seen);
  endtask
  task automatic t_preview_line();
    run({8'h44, 32'h0101003b}, 8'h44, 16'h0052, 32'h003b0001);
    check("fetch", {2'h1, 1'b1, 9'h03b}, mem_seen);
  endtask
  task automatic t_reg_write();
    run({8'h57, 32'h30120123}, 8'h57, 16'h0000, 32'h0);
    run({8'h52, 32'h30120000}, 8'h52, 16'h0004, 32'h30120123);
  endtask
  // Sleep refuses capture but keeps exposure; high definition ignores slot
  task automatic t_modes();
    mode = 2'h0;
    run({8'h43, 32'h00000000}, 8'hff, 16'h0003, 32'h43030300);
    run({8'h45, 32'h00110000}, 8'h45, 16'h0000, 32'h0);
    mode = 2'h3;
    run({8'h43, 32'h07000000}, 8'h43, 16'h0002, 32'h00110000);
    check("hd capture", {1'b1, 1'b0, 16'h0011},
          {cap_seen[19], cap_seen[16:0]});
  endtask
  // Sensor and capture failures, bad slot, bad terminator
  task automatic t_faults();
    mode = 2'h2;
    fail = 1'b1;
    run({8'h52, 32'h30120000}, 8'hff, 16'h0003, 32'h52040400);
    run({8'h43, 32'h01000000}, 8'hff, 16'h0003, 32'h43040500);
    fail = 1'b0;
    run({8'h44, 32'h04000000}, 8'hff, 16'h0003, 32'h44020600);
    term = 8'h0a;
    run({8'h45, 32'h000a0000}, 8'hff, 16'h0003, 32'h45010700);
    term = 8'h0d;
  endtask
  initial begin
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    t_default_exposure();
    t_set_exposure();
    t_errors();
    t_capture();
    t_preview_line();
    t_reg_write();
    t_modes();
    t_faults();
    conclude();
  end
endmodule
